// >>> sdrc_map.vh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef SDRC_MAP_VH
`define SDRC_MAP_VH
`define SDRC_OFS_REGULATOR_CONTROL    6'h00
`define SDRC_OFS_GAIN_SELECT          6'h04
`define SDRC_OFS_INPUT_CONNECT_OFFSET 6'h08
`define SDRC_OFS_INPUT_CHANNEL_SELECT 6'h0C
`define SDRC_OFS_RESULT_LOW_BYTE      6'h10
`define SDRC_OFS_RESULT_MIDDLE_BYTE   6'h14
`define SDRC_OFS_RESULT_HIGH_BYTE     6'h18
`define SDRC_OFS_CONV_CONTROL_FIRST   6'h1C
`define SDRC_OFS_CONV_CONTROL_SECOND  6'h20
`define SDRC_OFS_CONV_CLOCK_SELECT    6'h24
`define SDRC_RST_REGULATOR_CONTROL    8'h00
`define SDRC_RST_CONV_CONTROL_FIRST   8'h20
`define SDRC_RST_ZERO                 8'h00
`define SDRC_REG_ENABLE_BIT           7
`define SDRC_REG_BYPASS_BIT           2
`define SDRC_REG_WRITE_MASK           8'h87
`define SDRC_GAIN_WRITE_MASK          8'h7F
`define SDRC_CONNECT_WRITE_MASK       8'h7E
`define SDRC_CR0_WRITE_MASK           8'hFC
`define SDRC_CR1_WRITE_MASK           8'hE6
`define SDRC_CLK_WRITE_MASK           8'h1F
`define SDRC_FILTER_RESET_BIT         7
`define SDRC_SLEEP_BIT                6
`define SDRC_POWER_OFF_BIT            5
`define SDRC_OSR_LSB                  2
`define SDRC_FILTER_MODE_SELECT_LSB                 5
`define SDRC_EOC_BIT                  1
`define SDRC_CLK_DIRECT_CODE          5'h1F
`define SDRC_N_LONG                   5'h1E
`define SDRC_N_SHORT                  5'h0C
`define SDRC_BASE_SHIFT               5'h07
`define SDRC_LEVEL_2V4                12'h960
`define SDRC_LEVEL_2V6                12'hA28
`define SDRC_LEVEL_2V9                12'hB54
`define SDRC_LEVEL_3V3                12'hCE4
`define SDRC_SEL_AN_FIRST             4'h0
`define SDRC_SEL_AN_SECOND            4'h1
`define SDRC_SEL_SUPPLY_TAP           4'h6
`define SDRC_SEL_TEMP_SENSOR          4'h7
`define SDRC_RESP_OKAY                2'h0
`define SDRC_RESP_SLVERR              2'h2
`endif

// >>> sdrc_clk_div.v
// converter clock source strobe: system clock direct or divided by two and by divider plus one
`timescale 1ns/10ps
`include "sdrc_map.vh"
module sdrc_clk_div (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       run,
	input  wire [4:0] divider,
	output reg        source_tick
);
	reg [5:0] count;
	wire [5:0] limit;
	wire       direct;

	assign direct = (divider == `SDRC_CLK_DIRECT_CODE);
	// two times (divider plus one) system cycles per source period
	assign limit = {divider, 1'b1};

	always @(posedge aclk) begin
		if (!aresetn || !run) begin
			count       <= 6'h00;
			source_tick <= 1'b0;
		end else if (direct) begin
			count       <= 6'h00;
			source_tick <= 1'b1;
		end else if (count == limit) begin
			count       <= 6'h00;
			source_tick <= 1'b1;
		end else begin
			count       <= count + 6'h01;
			source_tick <= 1'b0;
		end
	end
endmodule

// >>> sdrc_sinc.v
// decimation filter: sums the one-bit modulator stream over doubling times oversampling samples
`timescale 1ns/10ps
`include "sdrc_map.vh"
module sdrc_sinc (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        clear,
	input  wire        sample_tick,
	input  wire        modulator_bit,
	input  wire [2:0]  osr_sel,
	input  wire        doubling,
	output reg  [23:0] result,
	output reg         done
);
	reg  signed [23:0] acc;
	reg         [15:0] count;
	wire        [15:0] last;
	wire        [4:0]  shift;
	wire signed [23:0] acc_next;

	// 16384 at code 000, halving per code, doubled when sample doubling is on
	assign last     = ((16'h8000 >> osr_sel) >> (doubling ? 1'b0 : 1'b1)) - 16'h0001;
	assign shift    = `SDRC_BASE_SHIFT + {2'b00, osr_sel} + {4'h0, ~doubling};
	assign acc_next = modulator_bit ? acc + 24'sh000001 : acc - 24'sh000001;

	always @(posedge aclk) begin
		if (!aresetn || clear) begin
			acc    <= 24'sh000000;
			count  <= 16'h0000;
			result <= 24'h000000;
			done   <= 1'b0;
		end else begin
			done <= 1'b0;
			if (sample_tick) begin
				if (count == last) begin
					result <= acc_next <<< shift;
					done   <= 1'b1;
					acc    <= 24'sh000000;
					count  <= 16'h0000;
				end else begin
					acc   <= acc_next;
					count <= count + 16'h0001;
				end
			end
		end
	end
endmodule

// >>> sdrc_top.v
// delta-sigma converter and regulator control with AXI4-Lite register slave
// Notes on behaviour
// - the two-bit voltage select gives 2.4V, 2.6V, 2.9V or 3.3V for codes 00 to 11.
// - the regulator is off only with converter power-off 1 and enable 0, output on with enable.
// - with enable 0 the output pin is pulled weakly low; the regulator draws nothing only with converter power-off 1.
// - bit 2 of the regulator control register turns the bypass on when 1.
// - results come at source rate over N times doubling times oversampling ratio.
// - the source clock is the system clock or system clock over two over divider plus one.
// - the source clock is divided by N of 12 or 30 chosen by the filter mode field.
// - the filter mode field chooses a sample doubling factor of 1 or 2.
// - filter mode 000 gives N 30 and doubling 2, and oversampling code 001 gives 8192.
// - each 24-bit result is read from three read-only byte registers.
// - the inputs serve as two single-ended or one differential channel.
// - a decimation filter turns the one-bit stream into 24-bit words in the result registers.
// - bits 6 to 3 of the regulator control register read as zero.
// - the positive and negative select fields route pins, sensor or supply taps.
// - converter power-off 0 means on and 1 off, and it resets to 1.
// - oversampling code 000 gives 16384, halving per code down to 128 at 111.
`timescale 1ns/10ps
`include "sdrc_map.vh"
module sdrc_top (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [5:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [5:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        modulator_bit_in,
	output wire        regulator_power_on,
	output wire        regulated_output,
	output wire        regulator_pulldown,
	output wire        regulator_bypass,
	output wire [11:0] regulator_level_mv,
	output wire        converter_active,
	output wire        converter_clock,
	output wire [2:0]  pga_gain_code,
	output wire [1:0]  adc_gain_code,
	output wire [1:0]  ref_gain_code,
	output wire        input_connect,
	output wire [1:0]  input_mux_code,
	output wire [2:0]  offset_code,
	output wire [3:0]  positive_input_route,
	output wire [3:0]  negative_input_route
);
	////////////////////////////////////////////////////////////////////////////////
	// decoding functions
	function [11:0] level_of;
		input [1:0] code;
		begin
			case (code)
				2'b00:   level_of = `SDRC_LEVEL_2V4;
				2'b01:   level_of = `SDRC_LEVEL_2V6;
				2'b10:   level_of = `SDRC_LEVEL_2V9;
				default: level_of = `SDRC_LEVEL_3V3;
			endcase
		end
	endfunction

	// one-hot route: first pin, second pin, supply tap, temperature sensor
	function [3:0] route_of;
		input [3:0] code;
		begin
			case (code)
				`SDRC_SEL_AN_FIRST:     route_of = 4'h1;
				`SDRC_SEL_AN_SECOND:    route_of = 4'h2;
				`SDRC_SEL_SUPPLY_TAP:   route_of = 4'h4;
				`SDRC_SEL_TEMP_SENSOR:  route_of = 4'h8;
				default:                route_of = 4'h0;
			endcase
		end
	endfunction

	function is_mapped;
		input [5:0] addr;
		begin
			is_mapped = (addr[1:0] == 2'b00) && (addr <= `SDRC_OFS_CONV_CLOCK_SELECT);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// registers
	reg  [7:0]  regulator_control;
	reg  [7:0]  gain_select;
	reg  [7:0]  input_connect_offset;
	reg  [7:0]  input_channel_select;
	reg  [7:0]  converter_control_first;
	reg  [7:0]  converter_control_second;
	reg  [7:0]  converter_clock_select;
	reg  [23:0] result_word;
	reg         conversion_done;

	reg         aw_held;
	reg         w_held;
	reg  [5:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg  [1:0]  mod_sync;
	reg  [4:0]  n_count;
	reg         converter_clock_divider_tick;
	reg  [7:0]  read_byte;

	wire        write_fire;
	wire        write_lane;
	wire [7:0]  wbyte;
	wire        power_off;
	wire        filter_reset;
	wire        sleeping;
	wire [2:0]  filter_mode;
	wire        n_is_long;
	wire        doubling;
	wire [4:0]  n_last;
	wire        source_tick;
	wire [23:0] sinc_result;
	wire        sinc_done;
	wire        eoc_clear;
	wire [2:0]  osr_sel;
	wire [4:0]  clock_divider;
	wire        filter_clear;

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel: address and data taken in either order
	assign s_axi_awready = aresetn && !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = aresetn && !w_held && !s_axi_bvalid;
	assign write_fire    = aw_held && w_held && !s_axi_bvalid;
	assign write_lane    = write_fire && w_strb[0] && is_mapped(aw_addr);
	assign wbyte         = w_data[7:0];

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 6'h00;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SDRC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (write_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= is_mapped(aw_addr) ? `SDRC_RESP_OKAY : `SDRC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control registers
	assign eoc_clear = write_lane && (aw_addr == `SDRC_OFS_CONV_CONTROL_SECOND)
		&& !wbyte[`SDRC_EOC_BIT];

	always @(posedge aclk) begin
		if (!aresetn) begin
			regulator_control        <= `SDRC_RST_REGULATOR_CONTROL;
			gain_select              <= `SDRC_RST_ZERO;
			input_connect_offset     <= `SDRC_RST_ZERO;
			input_channel_select     <= `SDRC_RST_ZERO;
			converter_control_first  <= `SDRC_RST_CONV_CONTROL_FIRST;
			converter_control_second <= `SDRC_RST_ZERO;
			converter_clock_select   <= `SDRC_RST_ZERO;
		end else if (write_lane) begin
			case (aw_addr)
				`SDRC_OFS_REGULATOR_CONTROL:
					regulator_control <= wbyte & `SDRC_REG_WRITE_MASK;
				`SDRC_OFS_GAIN_SELECT:
					gain_select <= wbyte & `SDRC_GAIN_WRITE_MASK;
				`SDRC_OFS_INPUT_CONNECT_OFFSET:
					input_connect_offset <= wbyte & `SDRC_CONNECT_WRITE_MASK;
				`SDRC_OFS_INPUT_CHANNEL_SELECT:
					input_channel_select <= wbyte;
				`SDRC_OFS_CONV_CONTROL_FIRST:
					converter_control_first <= wbyte & `SDRC_CR0_WRITE_MASK;
				`SDRC_OFS_CONV_CONTROL_SECOND:
					converter_control_second <= wbyte & `SDRC_CR1_WRITE_MASK
						& ~(8'h01 << `SDRC_EOC_BIT);
				`SDRC_OFS_CONV_CLOCK_SELECT:
					converter_clock_select <= wbyte & `SDRC_CLK_WRITE_MASK;
				default:
					regulator_control <= regulator_control;
			endcase
		end
	end

	// end of conversion flag: set by the filter, cleared by writing 0; set wins
	always @(posedge aclk) begin
		if (!aresetn) begin
			conversion_done <= 1'b0;
			result_word     <= 24'h000000;
		end else begin
			if (sinc_done) begin
				conversion_done <= 1'b1;
				result_word     <= sinc_result;
			end else if (eoc_clear) begin
				conversion_done <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	assign s_axi_arready = aresetn && !s_axi_rvalid;

	always @* begin
		read_byte = 8'h00;
		case (s_axi_araddr)
			`SDRC_OFS_REGULATOR_CONTROL:    read_byte = regulator_control;
			`SDRC_OFS_GAIN_SELECT:          read_byte = gain_select;
			`SDRC_OFS_INPUT_CONNECT_OFFSET: read_byte = input_connect_offset;
			`SDRC_OFS_INPUT_CHANNEL_SELECT: read_byte = input_channel_select;
			`SDRC_OFS_RESULT_LOW_BYTE:      read_byte = result_word[7:0];
			`SDRC_OFS_RESULT_MIDDLE_BYTE:   read_byte = result_word[15:8];
			`SDRC_OFS_RESULT_HIGH_BYTE:     read_byte = result_word[23:16];
			`SDRC_OFS_CONV_CONTROL_FIRST:   read_byte = converter_control_first;
			`SDRC_OFS_CONV_CONTROL_SECOND:
				read_byte = converter_control_second | {6'h00, conversion_done, 1'b0};
			`SDRC_OFS_CONV_CLOCK_SELECT:    read_byte = converter_clock_select;
			default:                        read_byte = 8'h00;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `SDRC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, read_byte};
			s_axi_rresp  <= is_mapped(s_axi_araddr) ? `SDRC_RESP_OKAY : `SDRC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// regulator
	assign power_off          = converter_control_first[`SDRC_POWER_OFF_BIT];
	assign regulator_power_on = !(power_off && !regulator_control[`SDRC_REG_ENABLE_BIT]);
	assign regulated_output   = regulator_control[`SDRC_REG_ENABLE_BIT];
	assign regulator_pulldown = !regulator_control[`SDRC_REG_ENABLE_BIT];
	assign regulator_bypass   = regulator_control[`SDRC_REG_BYPASS_BIT];
	assign regulator_level_mv = level_of(regulator_control[1:0]);

	////////////////////////////////////////////////////////////////////////////////
	// input routing and gain fields
	assign pga_gain_code        = gain_select[2:0];
	assign adc_gain_code        = gain_select[4:3];
	assign ref_gain_code        = gain_select[6:5];
	assign input_connect        = input_connect_offset[6];
	assign input_mux_code       = input_connect_offset[5:4];
	assign offset_code          = input_connect_offset[3:1];
	assign positive_input_route = route_of(input_channel_select[3:0]);
	assign negative_input_route = route_of(input_channel_select[7:4]);

	////////////////////////////////////////////////////////////////////////////////
	// converter clocking and data rate
	assign filter_reset     = converter_control_first[`SDRC_FILTER_RESET_BIT];
	assign sleeping         = converter_control_first[`SDRC_SLEEP_BIT];
	assign converter_active = !power_off && !sleeping;
	assign filter_mode      = converter_control_second[`SDRC_FILTER_MODE_SELECT_LSB +: 3];
	assign n_is_long        = !filter_mode[1];
	assign doubling         = !filter_mode[2];
	assign n_last           = (n_is_long ? `SDRC_N_LONG : `SDRC_N_SHORT) - 5'h01;
	assign converter_clock  = converter_clock_divider_tick;
	assign osr_sel          = converter_control_first[`SDRC_OSR_LSB +: 3];
	assign clock_divider    = converter_clock_select[4:0];
	// filter restarts on software reset, sleep or power-off
	assign filter_clear     = filter_reset || !converter_active;

	always @(posedge aclk) begin
		if (!aresetn) begin
			mod_sync <= 2'b00;
		end else begin
			mod_sync <= {mod_sync[0], modulator_bit_in};
		end
	end

	// converter clock is the source clock divided by N
	always @(posedge aclk) begin
		if (!aresetn || !converter_active) begin
			n_count   <= 5'h00;
			converter_clock_divider_tick <= 1'b0;
		end else begin
			converter_clock_divider_tick <= 1'b0;
			if (source_tick) begin
				if (n_count == n_last) begin
					n_count   <= 5'h00;
					converter_clock_divider_tick <= 1'b1;
				end else begin
					n_count <= n_count + 5'h01;
				end
			end
		end
	end

	sdrc_clk_div u_clk_div (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.run         (converter_active),
		.divider     (clock_divider),
		.source_tick (source_tick)
	);

	sdrc_sinc u_sinc (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.clear         (filter_clear),
		.sample_tick   (converter_clock_divider_tick),
		.modulator_bit (mod_sync[1]),
		.osr_sel       (osr_sel),
		.doubling      (doubling),
		.result        (sinc_result),
		.done          (sinc_done)
	);
endmodule

// >>> sdrc_props.sv
// assertion checker on the converter control top ports
`timescale 1ns/10ps
`include "sdrc_map.vh"
module sdrc_props (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        regulator_power_on,
	input wire        regulated_output,
	input wire        regulator_pulldown,
	input wire [11:0] regulator_level_mv,
	input wire        converter_clock,
	input wire [3:0]  positive_input_route,
	input wire [3:0]  negative_input_route
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
////////////////////////////////////////////////////////////////////////////////
	AST_LEVEL: assert property (regulator_level_mv inside {12'h960, 12'hA28,
		12'hB54, 12'hCE4}) else $error("regulator level outside the four codes");
	AST_POWER: assert property (regulated_output |-> regulator_power_on)
		else $error("output enabled with regulator off");
	AST_PULL: assert property (regulator_pulldown == !regulated_output)
		else $error("pulldown not opposite to enable");
	AST_WR_ANS: assert property (s_wr_both |-> ##[1:3] s_axi_bvalid)
		else $error("no write response");
	AST_B_HOLD: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read response");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	AST_R_ERR: assert property (s_axi_rvalid && s_axi_rresp == `SDRC_RESP_SLVERR
		|-> s_axi_rdata == 32'h0) else $error("error read with data");
	AST_CONV_GAP: assert property ($rose(converter_clock) |=> !converter_clock [*8])
		else $error("converter clock pulses too close");
	AST_ROUTE: assert property ($onehot0(positive_input_route)
		&& $onehot0(negative_input_route)) else $error("input route not one-hot");
endmodule

// >>> tb.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
`include "sdrc_map.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb;
	logic        aclk = 0, aresetn = 0, modulator_bit_in = 0;
	logic [5:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
	logic [31:0] s_axi_wdata = 0, rd_d;
	logic [3:0]  s_axi_wstrb = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
	logic        s_axi_arvalid = 0, s_axi_rready = 1;
	logic [1:0]  rsp;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp, adc_gain_code, ref_gain_code, input_mux_code;
	wire  [31:0] s_axi_rdata;
	wire         regulator_power_on, regulated_output, regulator_pulldown, regulator_bypass;
	wire         converter_active, converter_clock, input_connect;
	wire  [11:0] regulator_level_mv;
	wire  [2:0]  pga_gain_code, offset_code;
	wire  [3:0]  positive_input_route, negative_input_route;
	integer      fail_count = 0, n_tests = 0, k;
	time         t0;
	logic [11:0] lv [4] = '{12'h960, 12'hA28, 12'hB54, 12'hCE4};
	logic [3:0]  rc [6] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'h2, 4'h8};
	logic [3:0]  re [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h0};
	sdrc_top dut (.*);
	initial forever #10 aclk = ~aclk;
////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic hung;
		fail_count++;
		give_verdict;
	endtask
	task automatic wr(input [5:0] a, input [7:0] d, input [3:0] s = 4'hF);
		integer i;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (i == 40) hung;
		rsp = s_axi_bresp;
	endtask
	task automatic rd(input [5:0] a);
		integer i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (i == 40) hung;
		rd_d = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task automatic rck(input [5:0] a, input [7:0] e);
		rd(a);
		`CHK(rd_d, {24'h0, e})
	endtask
	task automatic per(input integer e);
		integer i, c;
		for (i = 0; i < 3; i++) begin
			c = 0;
			@(posedge aclk);
			while (!converter_clock && c < 200) begin
				@(posedge aclk);
				c++;
			end
		end
		`CHK(c + 1, e)
	endtask
	task automatic eoc;
		integer i;
		rd_d = 0;
		for (i = 0; i < 900 && !rd_d[1]; i++) rd(6'h20);
		if (!rd_d[1]) hung;
	endtask
////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rck(6'h00, 8'h00);
		rck(6'h1C, 8'h20);
		`CHK(regulator_power_on, 1'b0)
		`CHK(regulator_pulldown, 1'b1)
		`CHK(converter_active, 1'b0)
		$display("test reset done");
		for (k = 0; k < 4; k++) begin
			wr(6'h00, 8'h84 | k[7:0]);
			`CHK(regulator_level_mv, lv[k])
		end
		wr(6'h00, 8'hFF);
		rck(6'h00, 8'h87);
		`CHK(regulator_bypass, 1'b1)
		wr(6'h00, 8'h00, 4'h0);
		rck(6'h00, 8'h87);
		wr(6'h00, 8'h00);
		`CHK(regulator_bypass, 1'b0)
		for (k = 0; k < 4; k++) begin
			wr(6'h1C, k[1] ? 8'h20 : 8'h00);
			wr(6'h00, {k[0], 7'h0});
			`CHK(regulator_power_on, !(k[1] & ~k[0]))
			`CHK(regulated_output, k[0])
			`CHK(regulator_pulldown, ~k[0])
		end
		$display("test regulator done");
		for (k = 0; k < 6; k++) begin
			wr(6'h0C, {rc[k], rc[k]});
			`CHK(positive_input_route, re[k])
			`CHK(negative_input_route, re[k])
		end
		wr(6'h04, 8'hFF);
		rck(6'h04, 8'h7F);
		`CHK(pga_gain_code, 3'h7)
		`CHK(adc_gain_code, 2'h3)
		`CHK(ref_gain_code, 2'h3)
		wr(6'h08, 8'hFF);
		rck(6'h08, 8'h7E);
		`CHK(input_mux_code, 2'h3)
		`CHK(input_connect, 1'b1)
		`CHK(offset_code, 3'h7)
		wr(6'h10, 8'hFF);
		`CHK(rsp, 2'h0)
		rck(6'h10, 8'h00);
		wr(6'h28, 8'h55);
		`CHK(rsp, 2'h2)
		rck(6'h28, 8'h00);
		`CHK(rsp, 2'h2)
		$display("test registers done");
		wr(6'h24, 8'h1F);
		wr(6'h20, 8'hC0);
		wr(6'h1C, 8'h1C);
		`CHK(converter_active, 1'b1)
		wr(6'h1C, 8'h5C);
		`CHK(converter_active, 1'b0)
		wr(6'h1C, 8'h1C);
		per(12);
		wr(6'h20, 8'h00);
		per(30);
		wr(6'h24, 8'h00);
		per(60);
		wr(6'h24, 8'h1F);
		wr(6'h20, 8'hC0);
		$display("test clock done");
		modulator_bit_in <= 1'b1;
		wr(6'h1C, 8'h9C);
		wr(6'h1C, 8'h1C);
		eoc;
		rck(6'h10, 8'h00);
		rck(6'h14, 8'h00);
		rck(6'h18, 8'h40);
		modulator_bit_in <= 1'b0;
		wr(6'h1C, 8'h9C);
		wr(6'h20, 8'hC0);
		rck(6'h20, 8'hC0);
		wr(6'h1C, 8'h1C);
		eoc;
		t0 = $time;
		wr(6'h20, 8'hC0);
		eoc;
		`CHK(($time - t0) / 20 inside {[1530:1570]}, 1'b1)
		rck(6'h18, 8'hC0);
		rck(6'h14, 8'h00);
		$display("test conversion done");
		give_verdict;
	end
endmodule
bind sdrc_top sdrc_props chk (.*);
